//--- aux_acq_regs.svh
// Purpose : constants for the auxiliary acquisition control block
// Assumes : 10 MHz clock (100 ns period)
// Notes   : the settle step cycle count is derived from its time figures
`ifndef AUX_ACQ_REGS_SVH
`define AUX_ACQ_REGS_SVH
// ----------------------------------------------------------------------------
// bias output modes
// ----------------------------------------------------------------------------
`define BIAS_MODE_AUTO0     2'h0
`define BIAS_MODE_AUTO1     2'h1
`define BIAS_MODE_OFF       2'h2
`define BIAS_MODE_ON        2'h3
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS       100
`define SETTLE_STEP_US      6
`define SETTLE_STEP_CYC     ((`SETTLE_STEP_US * 1000) / `CLK_PERIOD_NS)
`define SETTLE_COUNT_MAX    10'h3ff
// ----------------------------------------------------------------------------
// code formats
// ----------------------------------------------------------------------------
`define ADC_FULL_SCALE      14'h3fff
`define CMP_FULL_SCALE      13'h1000
`define RESULT_RESET        16'h0000
`endif

//--- aux_acq_pkg.sv
// Purpose : types for the auxiliary acquisition control block
// Assumes : six auxiliary channels
// Notes   : carries per-channel configuration as one struct
package aux_acq_pkg;
  typedef struct packed {
    logic [5:0] aux_channel_enable;
    logic [5:0] aux_reference_select;
    logic [5:0] pin_general_enable;
  } chan_cfg_s;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PRESET = 3'b001,
    ST_SCAN   = 3'b010,
    ST_CONV   = 3'b011,
    ST_WAIT   = 3'b100
  } acq_state_e;
endpackage : aux_acq_pkg

//--- aux_input_acquisition_ctrl.sv
// Purpose : sequences the six auxiliary inputs, bias switch and result formats
// Assumes : converter front end supplies 14-bit oversampled codes per request
// Notes   : settling runs alongside the cell scan unless timing is deterministic
//
// Summary of operation
// - modes 00b/01b close bias switch at acquisition start, open at end.
// - mode 10b keeps bias off; mode 11b keeps bias driven always.
// - 10-bit settling count times 6 us per enabled aux channel.
// - settling delay inserted before the first aux conversion of an acquisition.
// - non-deterministic scans overlap settling with cell, block, diagnostic intervals.
// - deterministic scans wait out the whole settling delay after acquisition start, before main scan go.
// - each aux conversion is a 14-bit oversampled result in its own register.
// - ratiometric ADC code 0..3fff stored shifted left by two, max fffc.
// - ratiometric comparator code 0..1000, 16-bit form saturates at fff0.
// - ratiometric channel uses bias supply as reference for ADC and comparator.
// - reference-select 1 converts absolutely against fixed reference, saturating at full scale.
// - absolute ADC code left aligned in 16 bits with two zero LSBs.
// - channel converts only when enabled; reference follows its select bit.
// - general-purpose pin enable overrides aux enable for that port.
`timescale 1ns/1ps
`include "aux_acq_regs.svh"
module aux_input_acquisition_ctrl #(
  parameter int N_CH = 6
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [1:0]             bias_output_mode,
  input  wire logic [9:0]             aux_settle_count,
  input  wire aux_acq_pkg::chan_cfg_s chan_cfg,
  input  wire logic                   deterministic_filter_rate,
  input  wire logic                   acq_start,
  input  wire logic                   main_scan_done,
  input  wire logic                   conv_done,
  input  wire logic [13:0]            conv_code,
  input  wire logic [12:0]            cmp_code,
  output logic                        bias_output_pin,
  output logic                        main_scan_go,
  output logic                        conv_req,
  output logic [2:0]                  conv_channel,
  output logic                        conv_ref_ratio,
  output logic [N_CH*16-1:0]          aux_result_register,
  output logic [15:0]                 cmp_code_register,
  output logic                        acq_busy,
  output logic                        acq_done
);

  // --------------------------------------------------------------------------
  // channel qualification
  // --------------------------------------------------------------------------
  // a port claimed as a general pin never converts, whatever its aux enable
  logic [5:0] active_ch;
  assign active_ch = chan_cfg.aux_channel_enable & ~chan_cfg.pin_general_enable;

  // settling scales with enabled channels; count them once per acquisition
  logic [2:0] n_active;
  always_comb begin
    n_active = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n_active = n_active + {2'h0, active_ch[i]};
    end
  end

  // --------------------------------------------------------------------------
  // sequencer state
  // --------------------------------------------------------------------------
  aux_acq_pkg::acq_state_e state_q, state_d;
  logic [15:0]  step_q, step_d;          // cycles within one 6 us step
  logic [12:0]  settle_q, settle_d;      // remaining 6 us steps
  logic [2:0]   ch_q, ch_d;
  logic         scan_done_q, scan_done_d;
  logic         go_q, go_d;
  logic         req_q, req_d;
  logic         ref_q, ref_d;
  logic         busy_q, busy_d;
  logic         done_q, done_d;
  logic         bias_q, bias_d;
  logic [N_CH*16-1:0] res_q, res_d;
  logic [15:0]  cmp_q, cmp_d;

  // first active channel at or after a given index
  function automatic logic [3:0] next_ch(input logic [5:0] act, input logic [2:0] from);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 5; i >= 0; i--) begin
      if (act[i] && (i >= from)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : next_ch

  logic [3:0] nxt;
  logic       settle_end;
  assign settle_end = (settle_q == 13'h0000);

  // next-state and datapath computation
  always_comb begin
    state_d     = state_q;
    step_d      = step_q;
    settle_d    = settle_q;
    ch_d        = ch_q;
    scan_done_d = scan_done_q;
    go_d        = 1'b0;
    req_d       = 1'b0;
    ref_d       = ref_q;
    busy_d      = busy_q;
    done_d      = 1'b0;
    res_d       = res_q;
    cmp_d       = cmp_q;
    nxt         = next_ch(active_ch, ch_q);
    // settling countdown runs in any state once loaded
    if (!settle_end) begin
      if (step_q == 16'(`SETTLE_STEP_CYC - 1)) begin
        step_d   = 16'h0000;
        settle_d = settle_q - 13'h0001;
      end else begin
        step_d = step_q + 16'h0001;
      end
    end
    if (main_scan_done) begin
      scan_done_d = 1'b1;
    end
    case (state_q)
      aux_acq_pkg::ST_IDLE: begin
        if (acq_start) begin
          busy_d      = 1'b1;
          step_d      = 16'h0000;
          settle_d    = 13'({3'h0, aux_settle_count} * {10'h000, n_active});
          scan_done_d = 1'b0;
          ch_d        = 3'h0;
          if (deterministic_filter_rate) begin
            state_d = aux_acq_pkg::ST_PRESET;
          end else begin
            go_d    = 1'b1;
            state_d = aux_acq_pkg::ST_SCAN;
          end
        end
      end
      aux_acq_pkg::ST_PRESET: begin
        // fixed-rate modes must not stretch mid-sequence, so wait up front
        if (settle_end) begin
          go_d    = 1'b1;
          state_d = aux_acq_pkg::ST_SCAN;
        end
      end
      aux_acq_pkg::ST_SCAN: begin
        // aux conversions begin only after main scan and settling both end
        if (scan_done_q && settle_end) begin
          state_d = aux_acq_pkg::ST_CONV;
        end
      end
      aux_acq_pkg::ST_CONV: begin
        if (nxt[3]) begin
          busy_d  = 1'b0;
          done_d  = 1'b1;
          state_d = aux_acq_pkg::ST_IDLE;
        end else begin
          ch_d    = nxt[2:0];
          req_d   = 1'b1;
          ref_d   = ~chan_cfg.aux_reference_select[nxt[2:0]];
          state_d = aux_acq_pkg::ST_WAIT;
        end
      end
      aux_acq_pkg::ST_WAIT: begin
        if (conv_done) begin
          // converter already saturates above reference; keep left aligned
          res_d[ch_q*16 +: 16] = {conv_code, 2'h0};
          cmp_d = (cmp_code >= `CMP_FULL_SCALE) ? 16'hfff0 :
                  {cmp_code[11:0], 4'h0} - ({4'h0, cmp_code[11:0]} / 16'h0100);
          ch_d    = ch_q + 3'h1;
          state_d = (ch_q == 3'h5) ? aux_acq_pkg::ST_IDLE : aux_acq_pkg::ST_CONV;
          if (ch_q == 3'h5) begin
            busy_d = 1'b0;
            done_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = aux_acq_pkg::ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
    // bias switch follows the acquisition in automatic modes
    case (bias_output_mode)
      `BIAS_MODE_AUTO0,
      `BIAS_MODE_AUTO1: bias_d = busy_d;
      `BIAS_MODE_OFF:   bias_d = 1'b0;
      default:          bias_d = 1'b1;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= aux_acq_pkg::ST_IDLE;
      step_q      <= 16'h0000;
      settle_q    <= 13'h0000;
      ch_q        <= 3'h0;
      scan_done_q <= 1'b0;
      go_q        <= 1'b0;
      req_q       <= 1'b0;
      ref_q       <= 1'b0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      bias_q      <= 1'b0;
      res_q       <= '0;
      cmp_q       <= `RESULT_RESET;
    end else begin
      state_q     <= state_d;
      step_q      <= step_d;
      settle_q    <= settle_d;
      ch_q        <= ch_d;
      scan_done_q <= scan_done_d;
      go_q        <= go_d;
      req_q       <= req_d;
      ref_q       <= ref_d;
      busy_q      <= busy_d;
      done_q      <= done_d;
      bias_q      <= bias_d;
      res_q       <= res_d;
      cmp_q       <= cmp_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, all registered
  // --------------------------------------------------------------------------
  assign bias_output_pin     = bias_q;
  assign main_scan_go        = go_q;
  assign conv_req            = req_q;
  assign conv_channel        = ch_q;
  assign conv_ref_ratio      = ref_q;
  assign aux_result_register = res_q;
  assign cmp_code_register   = cmp_q;
  assign acq_busy            = busy_q;
  assign acq_done            = done_q;

endmodule : aux_input_acquisition_ctrl

//--- aux_acq_ctrl_properties.sv
// Purpose: port checks for the aux acquisition block
// Assumes: one clock, async active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module aux_acq_ctrl_checker #(
  parameter int N_CH = 6
) (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic [1:0]             bias_output_mode,
  input wire aux_acq_pkg::chan_cfg_s chan_cfg,
  input wire logic                   deterministic_filter_rate,
  input wire logic                   acq_start,
  input wire logic                   conv_done,
  input wire logic [13:0]            conv_code,
  input wire logic [12:0]            cmp_code,
  input wire logic                   bias_output_pin,
  input wire logic                   main_scan_go,
  input wire logic                   conv_req,
  input wire logic [2:0]             conv_channel,
  input wire logic                   conv_ref_ratio,
  input wire logic [N_CH*16-1:0]     aux_result_register,
  input wire logic [15:0]            cmp_code_register,
  input wire logic                   acq_busy,
  input wire logic                   acq_done
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_bias_off; bias_output_mode == 2'h2 |=> !bias_output_pin; endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias on in off mode");
  property p_bias_on; bias_output_mode == 2'h3 |=> bias_output_pin; endproperty
  a_bias_on: assert property (p_bias_on) else $error("bias off in on mode");
  property p_auto_start;
    acq_start && !acq_busy && !bias_output_mode[1] |=> bias_output_pin && acq_busy;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("bias not closed");
  // the pin was registered with the mode seen one edge earlier, like acq_done
  property p_auto_end;
    acq_done && !$past(bias_output_mode[1]) |-> !bias_output_pin;
  endproperty
  a_auto_end: assert property (p_auto_end) else $error("bias not opened");
  property p_go_free;
    acq_start && !acq_busy && !deterministic_filter_rate |=> main_scan_go;
  endproperty
  a_go_free: assert property (p_go_free) else $error("main scan stalled");
  property p_req_en;
    conv_req |-> chan_cfg.aux_channel_enable[conv_channel]
      && !chan_cfg.pin_general_enable[conv_channel];
  endproperty
  a_req_en: assert property (p_req_en) else $error("inactive channel converted");
  property p_req_ref;
    conv_req |-> conv_ref_ratio == !chan_cfg.aux_reference_select[conv_channel];
  endproperty
  a_req_ref: assert property (p_req_ref) else $error("wrong reference");
  property p_res;
    conv_done |=> aux_result_register[16*$past(conv_channel) +: 16] == {$past(conv_code), 2'h0};
  endproperty
  a_res: assert property (p_res) else $error("result not stored");
  property p_cmp;
    conv_done |=> cmp_code_register == 16'({$past(cmp_code), 4'h0} - ($past(cmp_code) >> 8));
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator code form");
endmodule : aux_acq_ctrl_checker
bind aux_input_acquisition_ctrl aux_acq_ctrl_checker #(.N_CH(N_CH)) u_chk (.*);

//--- aux_front_end_model.sv
// Purpose: converter and main scan model
// Assumes: answers every request after a few cycles
// Notes: conv_code inverts outside conv_done so stale data never matches
`timescale 1ns/1ps
module aux_front_end_model (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         main_scan_go,
  input wire logic         conv_req,
  input wire logic [2:0]   conv_channel,
  output logic             main_scan_done,
  output logic             conv_done,
  output logic [13:0]      conv_code,
  output logic [12:0]      cmp_code
);
  logic [3:0] scan_n, conv_n;
  logic [2:0] ch_q;
  // main scan lasts ten cycles, conversion three
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {scan_n, conv_n, ch_q, main_scan_done, conv_done} <= '0;
    end else begin
      main_scan_done <= scan_n == 4'h1;
      conv_done <= conv_n == 4'h1;
      scan_n <= main_scan_go ? 4'ha : scan_n - 4'(scan_n != 0);
      conv_n <= conv_req ? 4'h3 : conv_n - 4'(conv_n != 0);
      if (conv_req) ch_q <= conv_channel;
    end
  end
  // codes never exceed the 14-bit full scale
  assign conv_code = {14{!conv_done}} ^ (14'h3fff - {ch_q, 11'h0});
  assign cmp_code = (ch_q == 3'h0) ? 13'h1000 : 13'h0800;
endmodule : aux_front_end_model

//--- tb.sv
// Purpose: self-checking bench for the aux acquisition block
// Assumes: 10 MHz clock, inputs move on the falling edge
// Notes: settle windows bounded a few cycles either way
`timescale 1ns/1ps
module tb;
  logic clk, rstn, start, det, busy, done, go, req, ratio, bias, b_mid, sdone, cdone;
  logic [1:0] mode;
  logic [9:0] settle;
  logic [2:0] ch;
  logic [13:0] code;
  logic [12:0] cmp;
  logic [95:0] res;
  logic [15:0] cmpr;
  aux_acq_pkg::chan_cfg_s cfg;
  int n_mismatch, num_checks, t_go, t_req;
  aux_input_acquisition_ctrl u_aux_input_acquisition_ctrl (.clk(clk), .rstn(rstn),
    .bias_output_mode(mode), .aux_settle_count(settle), .chan_cfg(cfg),
    .deterministic_filter_rate(det), .acq_start(start), .main_scan_done(sdone),
    .conv_done(cdone), .conv_code(code), .cmp_code(cmp), .bias_output_pin(bias),
    .main_scan_go(go), .conv_req(req), .conv_channel(ch), .conv_ref_ratio(ratio),
    .aux_result_register(res), .cmp_code_register(cmpr), .acq_busy(busy), .acq_done(done));
  aux_front_end_model u_aux_front_end_model (.clk(clk), .rstn(rstn), .main_scan_go(go),
    .conv_req(req), .conv_channel(ch), .main_scan_done(sdone), .conv_done(cdone),
    .conv_code(code), .cmp_code(cmp));
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // one acquisition, timing go and first request from the start edge
  task automatic run_acq();
    int k;
    start = 1'b1;
    @(negedge clk) start = 1'b0;
    t_go = -1;
    t_req = -1;
    for (k = 1; k < 4000 && done !== 1'b1; k++) begin
      if (k == 2) b_mid = bias;
      if (go === 1'b1 && t_go < 0) t_go = k;
      if (req === 1'b1 && t_req < 0) t_req = k;
      @(negedge clk);
    end
    if (k >= 4000) begin
      n_mismatch++;
      final_report();
    end
  endtask : run_acq
  function automatic logic [15:0] exp_res(input logic [2:0] c);
    return {14'h3fff - {c, 11'h0}, 2'h0};
  endfunction : exp_res
  // free scan, mixed channels, one gated by its general pin
  task automatic sc_mixed();
    {mode, det, settle} = {2'h0, 1'b0, 10'h001};
    cfg = '{6'h2f, 6'h21, 6'h04};
    run_acq();
    chk("go_free", 16'(t_go), 16'h1);
    chk("settle", 16'(t_req >= 241 && t_req <= 246), 16'h1);
    chk("bias_mid", 16'(b_mid), 16'h1);
    chk("bias_end", 16'(bias), 16'h0);
    for (int c = 0; c < 6; c++) begin
      chk("res", res[16*c +: 16], (c == 2 || c == 4) ? 16'h0 : exp_res(3'(c)));
    end
    chk("cmp_half", cmpr, 16'h7ff8);
  endtask : sc_mixed
  // deterministic scan waits the full settle before go
  task automatic sc_det();
    {mode, det, settle} = {2'h2, 1'b1, 10'h002};
    cfg = '{6'h01, 6'h3f, 6'h00};
    run_acq();
    chk("go_det", 16'(t_go >= 120 && t_go <= 122), 16'h1);
    chk("bias_off", 16'(b_mid), 16'h0);
    chk("res_abs", res[15:0], 16'hfffc);
    chk("cmp_full", cmpr, 16'hfff0);
  endtask : sc_det
  // static on, then automatic code 01
  task automatic sc_static();
    {mode, det, settle} = {2'h3, 1'b0, 10'h000};
    cfg = '{6'h02, 6'h00, 6'h00};
    run_acq();
    chk("bias_on", {b_mid, bias}, 16'h3);
    chk("res_ratio_on", res[31:16], exp_res(3'h1));
    mode = 2'h1;
    run_acq();
    chk("bias_auto", {b_mid, bias}, 16'h2);
    chk("res_ratio", res[31:16], exp_res(3'h1));
  endtask : sc_static
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rstn, start, det, mode, settle} = '0;
    cfg = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    chk("res_rst", res[15:0], 16'h0);
    sc_mixed();
    sc_det();
    sc_static();
    final_report();
  end
endmodule : tb
